// ### dv/line_peer.sv
// Remote transceiver model driving the receive line
`timescale 1ns/1ps
module line_peer
#(
  parameter int BITC = 16
)
(
  input  wire logic hclk,
  output      logic rxd
);
  // Line idles at mark level
  initial rxd = 1'b1;

  // One frame: start, data LSB first, parity if on, stop
  task send(input logic [7:0] d, input logic pon, input logic pb,
            input logic sb);
    logic [10:0] f;
    int          n;
    f = {sb, pb, d, 1'b0};
    n = pon ? 11 : 10;
    if (!pon)
      f[9] = sb;
    for (int i = 0; i < n; i++)
    begin
      rxd <= f[i];
      repeat (BITC) @(posedge hclk);
    end
    rxd <= 1'b1;
  endtask

  // Line held low for n cycles, then back to mark
  task brk(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge hclk);
    rxd <= 1'b1;
  endtask
endmodule // line_peer

// ### dv/serial_line_checker.sv
// Port-level assertions for the serial line unit
`timescale 1ns/1ps
module serial_line_checker
  import serial_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxd,
  input wire logic        txd_out,
  input wire logic        txd_oe,
  input wire logic        rx_irq,
  input wire logic        err_irq,
  input wire logic [7:0]  hwdata_lo
);
  logic       tk;
  logic       rd_rx;
  logic       wr_st;
  logic       wr_ct;
  logic       wr_ct_q;
  logic [7:0] ctrl_sh;
  logic [7:0] low_n;

  // Address phases taken, by target
  assign tk    = hsel & htrans[1] & hready;
  assign rd_rx = tk & !hwrite & (haddr[7:0] == RXDATA_OFF);
  assign wr_st = tk & hwrite & (haddr[7:0] == STATUS_OFF);
  assign wr_ct = tk & hwrite & (haddr[7:0] == CTRL_OFF);

  // Control shadow and run length of low line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ct_q <= 1'b0;
      ctrl_sh <= CTRL_RST;
      low_n   <= 8'h00;
    end
    else
    begin
      wr_ct_q <= wr_ct;
      if (wr_ct_q)
        ctrl_sh <= hwdata_lo;
      low_n <= rxd ? 8'h00 : low_n + {7'h00, low_n != 8'hFF};
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_pin_port;
    !ctrl_sh[PINSEL_BIT] |-> txd_out == ctrl_sh[PDATA_BIT]
      && txd_oe == ctrl_sh[PDIR_BIT];
  endproperty
  a_pin_port: assert property (p_pin_port)
    else $error("pin not following port bits");
  property p_pin_now;
    $fell(ctrl_sh[PINSEL_BIT]) |-> (txd_out == ctrl_sh[PDATA_BIT])[*2];
  endproperty
  a_pin_now: assert property (p_pin_now)
    else $error("pin handover late");
  property p_rx_rise;
    $rose(rx_irq) |-> $past(rxd, 4);
  endproperty
  a_rx_rise: assert property (p_rx_rise)
    else $error("full flag set by bad frame");
  property p_full_hold;
    $fell(rx_irq) |-> $past(rd_rx) || $past(rd_rx, 2);
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full flag dropped without read");
  property p_rd_clr;
    rd_rx |-> ##2 !rx_irq;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("read did not clear full flag");
  property p_err_hold;
    $fell(err_irq) |-> $past(wr_st, 2);
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error flag cleared by itself");
  property p_ctrl_keep;
    wr_ct && err_irq |-> ##2 err_irq;
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("control write cleared errors");
  property p_break_again;
    $fell(err_irq) && low_n == 8'hFF |-> ##[1:400] (err_irq || rxd);
  endproperty
  a_break_again: assert property (p_break_again)
    else $error("framing error not raised again");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not ready okay");
endmodule // serial_line_checker

bind serial_line serial_line_checker u_serial_line_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd_out(txd_out),
  .txd_oe(txd_oe), .rx_irq(rx_irq), .err_irq(err_irq),
  .hwdata_lo(hwdata[7:0]));

// ### dv/tb.sv
// Self-checking bench for the serial line unit
`timescale 1ns/1ps
module tb;
  import serial_pkg::*;
  localparam logic [7:0]  C_TE = 8'h01 << TE_BIT;
  localparam logic [7:0]  C_RE = 8'h01 << RE_BIT;
  localparam logic [7:0]  C_SY = 8'h01 << SYNC_BIT;
  localparam logic [7:0]  C_PE = 8'h01 << PAREN_BIT;
  localparam logic [7:0]  C_PO = 8'h01 << PODD_BIT;
  localparam logic [7:0]  C_PS = 8'h01 << PINSEL_BIT;
  localparam logic [7:0]  C_PD = 8'h01 << PDATA_BIT;
  localparam logic [7:0]  C_PR = 8'h01 << PDIR_BIT;
  localparam logic [31:0] S_TD = 32'h1 << TX_HOLDING_EMPTY_FLAG_BIT;
  localparam logic [31:0] S_RF = 32'h1 << RX_HOLDING_FULL_FLAG_BIT;
  localparam logic [31:0] S_PA = 32'h1 << PER_BIT;
  localparam logic [31:0] S_FE = 32'h1 << FER_BIT;
  localparam logic [31:0] S_OR = 32'h1 << OVERRUN_ERROR_FLAG_BIT;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic        rxd;
  logic        txd_out;
  logic        txd_oe;
  logic        rx_irq;
  logic        err_irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [7:0]  pd;
  int          n_mismatch;
  int          checks_done;

  serial_line u_serial_line (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .rx_irq(rx_irq),
    .err_irq(err_irq));
  line_peer #(.BITC(16)) u_line_peer (.hclk(hclk), .rxd(rxd));

  // Clock, 50 ns period
  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single AHB-Lite word transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  // Bounded wait for a pin level
  task wait_tx(input logic v);
    int i;
    i = 0;
    while (txd_out !== v && i < 400)
    begin
      @(posedge hclk);
      i++;
    end
    chk(txd_out, v);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog on the whole run
  initial
  begin
    cyc(30000);
    n_mismatch++;
    wrap_up;
  end

  // Test sequence
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    hresetn = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    cyc(10);
    hresetn <= 1'b1;
    rd(CTRL_OFF, '1, {24'h0, CTRL_RST});
    rd(STATUS_OFF, '1, S_TD | (32'h1 << TEND_BIT));
    rd(BAUD_OFF, '1, {16'h0, BAUD_RST});
    wr(8'h14, 32'hFF);
    rd(8'h14, '1, 32'h0);
    $display("test reset done");
    wr(CTRL_OFF, C_RE | C_PS);
    u_line_peer.send(8'hA5, 1'b0, 1'b0, 1'b1);
    chk(rx_irq, 1);
    rd(RXDATA_OFF, '1, 32'hA5);
    rd(STATUS_OFF, S_RF, 32'h0);
    rd(RXDATA_OFF, '1, 32'hA5);
    u_line_peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
    cyc(2);
    u_line_peer.send(8'hC3, 1'b0, 1'b0, 1'b1);
    rd(STATUS_OFF, S_RF | S_OR, S_RF | S_OR);
    chk(err_irq, 1);
    rd(RXDATA_OFF, '1, 32'h3C);
    wr(STATUS_OFF, 32'h0);
    u_line_peer.send(8'h5A, 1'b0, 1'b0, 1'b0);
    rd(STATUS_OFF, S_RF | S_FE | S_OR, S_FE);
    rd(RXDATA_OFF, '1, 32'h5A);
    wr(STATUS_OFF, 32'h0);
    // Low tail of the bad stop bit starts a frame of ones
    cyc(300);
    rd(RXDATA_OFF, '1, 32'hFF);
    $display("test receive done");
    pd = 8'h01;
    for (int od = 0; od < 2; od++)
    begin
      wr(CTRL_OFF, C_RE | C_PS | C_PE | (od ? C_PO : 8'h00));
      u_line_peer.send(pd, 1'b1, (^pd) ^ od[0], 1'b1);
      rd(STATUS_OFF, S_PA | S_RF, S_RF);
      rd(RXDATA_OFF, '1, {24'h0, pd});
      u_line_peer.send(~pd, 1'b1, ~((^pd) ^ od[0]), 1'b1);
      rd(STATUS_OFF, S_PA | S_RF, S_PA);
      rd(RXDATA_OFF, '1, {24'h0, ~pd});
      wr(STATUS_OFF, 32'h0);
    end
    $display("test parity done");
    wr(CTRL_OFF, C_RE | C_PS);
    fork
      u_line_peer.brk(1200);
    join_none
    cyc(400);
    rd(STATUS_OFF, S_FE, S_FE);
    wr(STATUS_OFF, 32'h0);
    cyc(300);
    rd(STATUS_OFF, S_FE, S_FE);
    wr(CTRL_OFF, C_PS);
    rd(STATUS_OFF, S_FE, S_FE);
    cyc(700);
    chk(err_irq, 1);
    $display("test break done");
    wr(CTRL_OFF, C_TE | C_SY | C_PS);
    wr(TXDATA_OFF, 32'h55);
    cyc(40);
    chk(txd_out, 1);
    rd(STATUS_OFF, S_TD, 32'h0);
    wr(STATUS_OFF, 32'h0);
    wait_tx(1'b0);
    cyc(200);
    rd(STATUS_OFF, S_TD, S_TD);
    $display("test sync block done");
    wr(CTRL_OFF, C_PR);
    cyc(1);
    chk({txd_oe, txd_out}, 2);
    wr(CTRL_OFF, C_PD | C_PR);
    cyc(1);
    chk({txd_oe, txd_out}, 3);
    wr(CTRL_OFF, C_TE | C_PS | C_PD | C_PR);
    wr(TXDATA_OFF, 32'hF0);
    wait_tx(1'b0);
    wait_tx(1'b1);
    wr(CTRL_OFF, C_TE | C_PS | C_PR);
    wr(CTRL_OFF, C_TE | C_PR);
    cyc(1);
    chk({txd_oe, txd_out}, 2);
    $display("test pin done");
    wrap_up;
  end
endmodule // tb

// ### include/rx_status_if.sv
// Receive-side status carrier between receiver and register file
`timescale 1ns/1ps
interface rx_status_if;
  logic       done;    // one-cycle pulse at frame end
  logic [7:0] data;
  logic       framing_error_flag;
  logic       parity_error_flag;

  modport rx  (output done, output data, output framing_error_flag, output parity_error_flag);
  modport top (input done, input data, input framing_error_flag, input parity_error_flag);
endinterface

// ### include/serial_pkg.sv
// Constants, register map and bit timing for the serial status and line block
//
// Notes on behaviour
// - Error frame without overrun keeps full flag as before, byte still loaded.
// - Continuous low input reads as zero frames, raising framing error.
// - Receiver keeps running in break, so a cleared framing flag returns.
// - Pin select cleared makes transmit pin a port driven by data/direction bits.
// - Pin select clear hands pin to port at once, whatever transmit is doing.
// - Synchronous mode: no transmit frame starts while any receive error flag is set.
// - Clearing receive enable leaves receive error flags unchanged.
// - Asynchronous timing uses a base clock sixteen times the bit rate.
// - Receiver aligns to start bit falling edge sampled on base clock.
// - Each bit is captured at the eighth base clock of the bit.
// - Frame end with full flag clear is normal, with it set is overrun.
// - Reading the receive holding register clears the full flag, unless an overrun frame ends in the read's data phase.
// - Holding register updates at frame end; coincident read may see new byte.
// - On overrun the new byte is not moved in and is lost.
// - Full flag requests receive interrupt; error flags request error interrupt.
package serial_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] TXDATA_OFF = 8'h08;
  localparam logic [7:0] RXDATA_OFF = 8'h0C;
  localparam logic [7:0] BAUD_OFF   = 8'h10;

  // Control field positions
  localparam int TE_BIT    = 0;
  localparam int RE_BIT    = 1;
  localparam int SYNC_BIT  = 2;
  localparam int PAREN_BIT = 3;
  localparam int PODD_BIT  = 4;
  localparam int PINSEL_BIT = 5;
  localparam int PDATA_BIT = 6;
  localparam int PDIR_BIT  = 7;

  // Status field positions
  localparam int TX_HOLDING_EMPTY_FLAG_BIT = 0;
  localparam int TEND_BIT = 1;
  localparam int RX_HOLDING_FULL_FLAG_BIT = 2;
  localparam int PER_BIT  = 3;
  localparam int FER_BIT  = 4;
  localparam int OVERRUN_ERROR_FLAG_BIT = 5;

  // Reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] BAUD_RST   = 16'h0001;

  // Bit timing
  localparam int          OVERSAMPLE = 16;
  localparam logic [3:0]  SAMPLE_TICK = 4'h7; // eighth pulse, zero based
  localparam logic [3:0]  LAST_TICK   = 4'hF;
  localparam logic [3:0]  DATA_BITS   = 4'h8;

endpackage

// ### verilog/serial_baud.sv
// Base clock divider producing one-cycle tick enables
`timescale 1ns/1ps
module serial_baud
  import serial_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [DIV_W-1:0] divisor,
  output      logic             tick
);
  typedef struct packed
  {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } baud_state_type;

  baud_state_type st_reg;
  baud_state_type st_next;

  initial
  begin
    if (DIV_W < 2)
      $error("DIV_W too small");
  end

  // Count up and pulse at divisor
  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt + DIV_W'(1) >= divisor)
    begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end
    else
      st_next.cnt = st_reg.cnt + DIV_W'(1);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;
endmodule // serial_baud

// ### verilog/serial_line.sv
// Serial unit top: AHB-Lite registers, transmitter, status and pin control
`timescale 1ns/1ps
module serial_line
  import serial_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  input  wire logic        rxd,
  output      logic        txd_out,
  output      logic        txd_oe,
  output      logic        rx_irq,
  output      logic        err_irq
);
  typedef enum {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_phase_type;

  typedef struct packed
  {
    // Receive pin synchroniser
    logic         rx_m;
    logic         rx_s;
    // Bus pipeline
    logic         wr_pend;
    logic         rd_pend;
    logic [7:0]   addr;
    logic [31:0]  rdata;
    // Software registers
    logic [7:0]   ctrl;
    logic [15:0]  baud;
    logic [7:0]   tdr;
    logic [7:0]   rx_holding_reg;
    // Status flags
    logic         tx_holding_empty_flag;
    logic         tend;
    logic         rx_holding_full_flag;
    logic         parity_error_flag;
    logic         framing_error_flag;
    logic         overrun_error_flag;
    // Transmitter
    tx_phase_type tphase;
    logic [3:0]   tsub;
    logic [3:0]   tbit;
    logic [7:0]   tsr;
    logic         tpar;
    logic         txd;
  } top_state_type;

  top_state_type r_reg;
  top_state_type r_next;
  logic          tick;
  logic          err_any;
  logic          addr_ok;
  logic          rx_load;
  logic          tx_go;
  logic [7:0]    rx_view;
  logic [31:0]   status_word;
  rx_status_if   rxs ();

  // Base clock at sixteen times bit rate
  serial_baud #(.DIV_W(16)) u_baud
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .divisor (r_reg.baud),
    .tick    (tick)
  );

  serial_rx u_rx
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .rxd_s   (r_reg.rx_s),
    .enable  (r_reg.ctrl[RE_BIT]),
    .par_en  (r_reg.ctrl[PAREN_BIT]),
    .par_odd (r_reg.ctrl[PODD_BIT]),
    .st      (rxs.rx)
  );

  assign err_any = r_reg.parity_error_flag | r_reg.framing_error_flag | r_reg.overrun_error_flag;
  assign addr_ok = hsel && htrans[1] && hready;

  // Frame end with room in the holding register
  assign rx_load = rxs.done && !r_reg.rx_holding_full_flag;

  assign rx_view = rx_load ? rxs.data : r_reg.rx_holding_reg;

  assign tx_go = r_reg.ctrl[TE_BIT] && !r_reg.tx_holding_empty_flag &&
                 !(r_reg.ctrl[SYNC_BIT] && err_any);

  // Status word at its field positions
  always_comb
  begin
    status_word           = 32'h00000000;
    status_word[TX_HOLDING_EMPTY_FLAG_BIT] = r_reg.tx_holding_empty_flag;
    status_word[TEND_BIT] = r_reg.tend;
    status_word[RX_HOLDING_FULL_FLAG_BIT] = r_reg.rx_holding_full_flag;
    status_word[PER_BIT]  = r_reg.parity_error_flag;
    status_word[FER_BIT]  = r_reg.framing_error_flag;
    status_word[OVERRUN_ERROR_FLAG_BIT] = r_reg.overrun_error_flag;
  end

  // Control and status fields must fit one byte
  initial
  begin
    if (PDIR_BIT >= $bits(r_reg.ctrl) || OVERRUN_ERROR_FLAG_BIT >= $bits(r_reg.ctrl))
      $error("control or status field outside byte");
  end

  // Bus, status flags and transmitter
  always_comb
  begin
    r_next         = r_reg;
    r_next.rx_m    = rxd;
    r_next.rx_s    = r_reg.rx_m;
    r_next.wr_pend = 1'b0;
    r_next.rd_pend = 1'b0;

    // Address phase capture and read data
    if (addr_ok)
    begin
      r_next.addr    = haddr[7:0];
      r_next.wr_pend = hwrite;
      r_next.rd_pend = !hwrite;
      unique case (haddr[7:0])
        CTRL_OFF:   r_next.rdata = {24'h000000, r_reg.ctrl};
        STATUS_OFF: r_next.rdata = status_word;
        TXDATA_OFF: r_next.rdata = {24'h000000, r_reg.tdr};
        RXDATA_OFF: r_next.rdata = {24'h000000, rx_view};
        BAUD_OFF:   r_next.rdata = {16'h0000, r_reg.baud};
        default:    r_next.rdata = 32'h00000000;
      endcase
    end

    // Data phase write
    if (r_reg.wr_pend)
    begin
      unique case (r_reg.addr)
        CTRL_OFF: r_next.ctrl = hwdata[7:0];
        STATUS_OFF:
        begin
          if (!hwdata[PER_BIT])
            r_next.parity_error_flag = 1'b0;
          if (!hwdata[FER_BIT])
            r_next.framing_error_flag = 1'b0;
          if (!hwdata[OVERRUN_ERROR_FLAG_BIT])
            r_next.overrun_error_flag = 1'b0;
        end
        TXDATA_OFF:
        begin
          r_next.tdr  = hwdata[7:0];
          r_next.tx_holding_empty_flag = 1'b0;
        end
        BAUD_OFF: r_next.baud = hwdata[15:0];
        default: ;
      endcase
    end

    // Read of holding register clears full
    if (r_reg.rd_pend && r_reg.addr == RXDATA_OFF)
      r_next.rx_holding_full_flag = 1'b0;

    if (rxs.done)
    begin
      if (r_reg.rx_holding_full_flag)
      begin
        r_next.overrun_error_flag = 1'b1;
        r_next.rx_holding_full_flag = 1'b1;
        if (rxs.framing_error_flag)
          r_next.framing_error_flag = 1'b1;
        if (rxs.parity_error_flag)
          r_next.parity_error_flag = 1'b1;
      end
      else
      begin
        r_next.rx_holding_reg = rxs.data;
        if (rxs.framing_error_flag || rxs.parity_error_flag)
        begin
          r_next.rx_holding_full_flag = r_reg.rx_holding_full_flag;
          r_next.framing_error_flag = r_next.framing_error_flag | rxs.framing_error_flag;
          r_next.parity_error_flag = r_next.parity_error_flag | rxs.parity_error_flag;
        end
        else
          r_next.rx_holding_full_flag = 1'b1;
      end
    end

    // Transmitter
    if (tick)
    begin
      r_next.tsub = r_reg.tsub + 4'h1;
      unique case (r_reg.tphase)
        T_IDLE:
        begin
          r_next.txd  = 1'b1;
          r_next.tsub = 4'h0;
          if (tx_go)
          begin
            r_next.tsr    = r_reg.tdr;
            r_next.tx_holding_empty_flag   = 1'b1;
            r_next.tend   = 1'b0;
            r_next.tphase = T_START;
            r_next.txd    = 1'b0;
            r_next.tpar   = r_reg.ctrl[PODD_BIT];
          end
        end
        // Start bit for one bit time
        T_START:
        begin
          if (r_reg.tsub == LAST_TICK)
          begin
            r_next.tphase = T_DATA;
            r_next.tbit   = 4'h0;
            r_next.txd    = r_reg.tsr[0];
          end
        end
        // Data bits, lowest first
        T_DATA:
        begin
          if (r_reg.tsub == LAST_TICK)
          begin
            r_next.tpar = r_reg.tpar ^ r_reg.tsr[0];
            r_next.tsr  = {1'b0, r_reg.tsr[7:1]};
            r_next.tbit = r_reg.tbit + 4'h1;
            r_next.txd  = r_reg.tsr[1];
            if (r_reg.tbit == DATA_BITS - 4'h1)
            begin
              r_next.tphase = r_reg.ctrl[PAREN_BIT] ? T_PAR : T_STOP;
              r_next.txd    = r_reg.ctrl[PAREN_BIT] ?
                              (r_reg.tpar ^ r_reg.tsr[0]) : 1'b1;
            end
          end
        end
        // Parity bit when enabled
        T_PAR:
        begin
          if (r_reg.tsub == LAST_TICK)
          begin
            r_next.tphase = T_STOP;
            r_next.txd    = 1'b1;
          end
        end
        // Stop bit, then back to idle
        T_STOP:
        begin
          if (r_reg.tsub == LAST_TICK)
          begin
            r_next.tphase = T_IDLE;
            r_next.tend   = r_reg.tx_holding_empty_flag;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r_reg <= '{tphase: T_IDLE, rx_m: 1'b1, rx_s: 1'b1, ctrl: CTRL_RST,
                 baud: BAUD_RST, tx_holding_empty_flag: 1'b1, tend: 1'b1, txd: 1'b1,
                 default: '0};
    else
      r_reg <= r_next;
  end

  // Port takes pin when select clear
  // Immediate handover, break drives port value
  always_comb
  begin
    if (r_reg.ctrl[PINSEL_BIT])
    begin
      txd_out = r_reg.txd;
      txd_oe  = r_reg.ctrl[TE_BIT];
    end
    else
    begin
      txd_out = r_reg.ctrl[PDATA_BIT];
      txd_oe  = r_reg.ctrl[PDIR_BIT];
    end
  end

  assign rx_irq    = r_reg.rx_holding_full_flag;
  assign err_irq   = err_any;
  assign hrdata    = r_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule // serial_line

// ### verilog/serial_rx.sv
// Oversampled asynchronous receiver
`timescale 1ns/1ps
module serial_rx
  import serial_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tick,
  input  wire logic rxd_s,
  input  wire logic enable,
  input  wire logic par_en,
  input  wire logic par_odd,
  rx_status_if.rx   st
);
  typedef enum {IDLE, START, DATA, PAR, STOP} rx_phase_type;

  typedef struct packed
  {
    rx_phase_type phase;
    logic [3:0]   sub;
    logic [3:0]   nbit;
    logic [7:0]   shift;
    logic         parity;
    logic         prev;
    logic         done;
    logic [7:0]   data;
    logic         framing_error_flag;
    logic         parity_error_flag;
  } rx_state_type;

  rx_state_type s_reg;
  rx_state_type s_next;

  // Frame sequencer
  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    if (tick)
    begin
      s_next.prev = rxd_s;
      s_next.sub  = s_reg.sub + 4'h1;
      unique case (s_reg.phase)
        IDLE:
        begin
          if (enable && s_reg.prev && !rxd_s)
          begin
            s_next.phase = START;
            s_next.sub   = 4'h1;
          end
        end
        START:
        begin
          if (s_reg.sub == SAMPLE_TICK)
          begin
            if (rxd_s)
              s_next.phase = IDLE;
          end
          if (s_reg.sub == LAST_TICK)
          begin
            s_next.phase  = DATA;
            s_next.nbit   = 4'h0;
            s_next.parity = par_odd;
          end
        end
        DATA:
        begin
          if (s_reg.sub == SAMPLE_TICK)
          begin
            s_next.shift  = {rxd_s, s_reg.shift[7:1]};
            s_next.parity = s_reg.parity ^ rxd_s;
          end
          if (s_reg.sub == LAST_TICK)
          begin
            s_next.nbit = s_reg.nbit + 4'h1;
            if (s_reg.nbit == DATA_BITS - 4'h1)
              s_next.phase = par_en ? PAR : STOP;
          end
        end
        PAR:
        begin
          if (s_reg.sub == SAMPLE_TICK)
            s_next.parity = s_reg.parity ^ rxd_s;
          if (s_reg.sub == LAST_TICK)
            s_next.phase = STOP;
        end
        STOP:
        begin
          if (s_reg.sub == SAMPLE_TICK)
          begin
            s_next.done  = 1'b1;
            s_next.data  = s_reg.shift;
            s_next.framing_error_flag   = !rxd_s;
            s_next.parity_error_flag   = par_en && s_reg.parity;
            s_next.phase = IDLE;
            s_next.prev  = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_reg <= '{phase: IDLE, prev: 1'b1, default: '0};
    else
      s_reg <= s_next;
  end

  assign st.done = s_reg.done;
  assign st.data = s_reg.data;
  assign st.framing_error_flag  = s_reg.framing_error_flag;
  assign st.parity_error_flag  = s_reg.parity_error_flag;
endmodule // serial_rx
